// ### hdl/iosp_defs.svh
// Offsets, field positions, reset values and timing counts for the sample packer
`ifndef IOSP_DEFS_SVH
`define IOSP_DEFS_SVH
`define IOSP_NUM_LINES        20
`define IOSP_NUM_ANALOG       4
`define IOSP_CFG_ANALOG       3'h2
`define IOSP_CFG_DIN          3'h3
`define IOSP_CFG_DOUT_LO      3'h4
`define IOSP_CFG_DOUT_HI      3'h5
`define IOSP_SAMPLE_SETS      8'h01
`define IOSP_VALID_LINES      20'hFF3FF
`define IOSP_ANALOG_LINES     20'h0000F
`define IOSP_ADDR_CTRL        12'h000
`define IOSP_ADDR_RATE        12'h004
`define IOSP_ADDR_CHG_MASK    12'h008
`define IOSP_ADDR_DEST_HI     12'h00C
`define IOSP_ADDR_DEST_LO     12'h010
`define IOSP_ADDR_PULL_EN     12'h014
`define IOSP_ADDR_PULL_DIR    12'h018
`define IOSP_ADDR_AREF        12'h01C
`define IOSP_ADDR_CFG_LO      12'h020
`define IOSP_ADDR_CFG_HI      12'h024
`define IOSP_ADDR_STATUS      12'h028
`define IOSP_ADDR_IRQ_STAT    12'h02C
`define IOSP_ADDR_IRQ_MASK    12'h030
`define IOSP_ADDR_PROTO       12'h034
`define IOSP_ADDR_RESULT      12'h038
`define IOSP_PULL_RESET       20'hFFFFF
`define IOSP_PULL_DIR_RESET   20'hFFFFF
`define IOSP_TICK_NS          1000
`define IOSP_CLK_NS           10
`define IOSP_TICK_CYCLES      (`IOSP_TICK_NS / `IOSP_CLK_NS)
`define IOSP_CTRL_IS_BIT      0
`define IOSP_CTRL_WAKE_BIT    1
`define IOSP_CTRL_PINWAKE_BIT 2
`define IOSP_IRQ_DONE_BIT     0
`define IOSP_IRQ_ERR_BIT      1
`define IOSP_IRQ_DROP_BIT     2
`endif

// ### hdl/iosp_packer.sv
// Pin configuration, sampling triggers and sample record packer
// Summary of operation
// R1 - Lines 0-9 and 12-19 configurable per line
// R2 - Config 3 input, 4 low, 5 high
// R3 - Per-pin pull enable and direction, default up
// R4 - Config 2 analog only on lines 0-3
// R5 - Analog value 10 bits in two bytes
// R6 - No configured lines means no sample
// R7 - Timer and change samples go to destination
// R8 - Sample on timer expiry and non-pin wake
// R9 - Masked digital input change makes a sample
// R10 - Immediate request returns present state
// R11 - Three sample sources work independently
// R12 - First byte sample-set count, always one
// R13 - Analog mask byte, bits 0-3
// R14 - Digital state word, omitted if mask zero
// R15 - Analog values ascending, none if mask zero
// R16 - Receiver uses frame protocol, type 0x92
// R17 - Digital mask word follows the count
// R18 - Two-byte fields go high byte first
`include "iosp_defs.svh"
module iosp_packer
(
	// Clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rstn,
	// APB slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [11:0]          paddr,
	input  wire logic [31:0]          pwdata,
	output logic                      pready,
	output logic [31:0]               prdata,
	output logic                      pslverr,
	// General pins
	input  wire logic [19:0]          general_pin_in,
	output logic [19:0]               general_pin_out,
	output logic [19:0]               general_pin_oe,
	output logic [19:0]               pull_resistor_enable,
	output logic [19:0]               pull_direction,
	output logic [1:0]                analog_reference_select,
	// Analog results
	input  wire logic [39:0]          analog_value,
	// Sample byte stream
	output logic                      sample_valid,
	output logic [7:0]                sample_byte,
	output logic                      sample_last,
	output iosp_pkg::iosp_src_t       sample_src,
	output logic [15:0]               dest_addr_high,
	output logic [15:0]               dest_addr_low,
	input  wire logic                 sample_ready,
	// Interrupt
	output logic                      irq
);
	import iosp_pkg::*;

	logic [2:0]   cfg_r [20];
	logic [15:0]  sample_rate_r;
	logic [19:0]  change_detect_mask_r;
	logic [1:0]   frame_protocol_select_r;
	logic [2:0]   irq_stat_r;
	logic [2:0]   irq_mask_r;
	logic [19:0]  sync1_r;
	logic [19:0]  sync2_r;
	logic [19:0]  sync3_r;
	logic [19:0]  din_level_r;
	logic [19:0]  din_prev_r;
	logic [19:0]  dmask;
	logic [19:0]  dout_hi;
	logic [3:0]   amask;
	logic [15:0]  tick_cnt_r;
	logic [15:0]  rate_cnt_r;
	logic         pend_timer_r;
	logic         pend_change_r;
	logic         pend_demand_r;
	iosp_state_t  state_r;
	logic         lo_half_r;
	logic [1:0]   ach_r;
	logic [19:0]  cap_dmask_r;
	logic [19:0]  cap_dstate_r;
	logic [3:0]   cap_amask_r;
	logic [39:0]  cap_aval_r;
	logic [31:0]  result_r;
	logic         setup;
	logic         wr;
	logic         rd;
	logic         is_req;
	logic         wake_req;
	logic         timer_hit;
	logic         change_hit;
	logic         start;
	logic         adv;
	logic [3:0]   amask_rest;

	// Per-line function decode
	genvar g;
	generate
		for (g = 0; g < `IOSP_NUM_LINES; g++)
		begin : gen_line
			if (((`IOSP_VALID_LINES >> g) & 1) != 0)
			begin : gen_valid
				assign dmask[g]   = (cfg_r[g] == `IOSP_CFG_DIN) || (cfg_r[g] == `IOSP_CFG_DOUT_LO) ||
					(cfg_r[g] == `IOSP_CFG_DOUT_HI); // R1 R2
				assign dout_hi[g] = (cfg_r[g] == `IOSP_CFG_DOUT_HI); // R2
			end
			else
			begin : gen_none
				assign dmask[g]   = 1'b0;
				assign dout_hi[g] = 1'b0;
			end
			if (g < `IOSP_NUM_ANALOG)
			begin : gen_an
				assign amask[g] = (cfg_r[g] == `IOSP_CFG_ANALOG); // R4
			end
		end
	endgenerate

	assign setup    = psel && !penable;
	assign wr       = psel && penable && pready && pwrite;
	assign rd       = setup && !pwrite;
	assign is_req   = wr && (paddr == `IOSP_ADDR_CTRL) && pwdata[`IOSP_CTRL_IS_BIT];
	assign wake_req = wr && (paddr == `IOSP_ADDR_CTRL) && pwdata[`IOSP_CTRL_WAKE_BIT] &&
		!pwdata[`IOSP_CTRL_PINWAKE_BIT]; // R8
	assign timer_hit  = (sample_rate_r != 16'h0000) && (tick_cnt_r == 16'h0000) &&
		(rate_cnt_r <= 16'h0001); // R8
	assign change_hit = |((din_level_r ^ din_prev_r) & change_detect_mask_r & dmask); // R9
	assign start      = adv && (state_r == IOSP_IDLE) && (pend_demand_r || pend_timer_r || pend_change_r);
	assign adv        = !sample_valid || sample_ready;
	assign amask_rest = cap_amask_r & ~((4'h2 << ach_r) - 4'h1);

	// APB register writes
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < `IOSP_NUM_LINES; i++)
				cfg_r[i] <= 3'h0;
			sample_rate_r           <= 16'h0000;
			change_detect_mask_r    <= 20'h00000;
			dest_addr_high          <= 16'h0000;
			dest_addr_low           <= 16'h0000;
			pull_resistor_enable    <= `IOSP_PULL_RESET; // R3
			pull_direction          <= `IOSP_PULL_DIR_RESET; // R3
			analog_reference_select <= 2'h0;
			irq_mask_r              <= 3'h0;
			frame_protocol_select_r <= 2'h0;
		end
		else if (wr)
		begin
			unique case (paddr)
				`IOSP_ADDR_RATE:     sample_rate_r <= pwdata[15:0];
				`IOSP_ADDR_CHG_MASK: change_detect_mask_r <= pwdata[19:0] & `IOSP_VALID_LINES;
				`IOSP_ADDR_DEST_HI:  dest_addr_high <= pwdata[15:0];
				`IOSP_ADDR_DEST_LO:  dest_addr_low <= pwdata[15:0];
				`IOSP_ADDR_PULL_EN:  pull_resistor_enable <= pwdata[19:0]; // R3
				`IOSP_ADDR_PULL_DIR: pull_direction <= pwdata[19:0]; // R3
				`IOSP_ADDR_AREF:     analog_reference_select <= pwdata[1:0];
				`IOSP_ADDR_IRQ_MASK: irq_mask_r <= pwdata[2:0];
				`IOSP_ADDR_PROTO:    frame_protocol_select_r <= pwdata[1:0];
				`IOSP_ADDR_CFG_LO:
					for (int i = 0; i < 10; i++)
						if (i >= `IOSP_NUM_ANALOG && pwdata[3*i +: 3] == `IOSP_CFG_ANALOG)
							cfg_r[i] <= 3'h0; // R4
						else
							cfg_r[i] <= pwdata[3*i +: 3]; // R1
				`IOSP_ADDR_CFG_HI:
					for (int i = 0; i < 10; i++)
						if (pwdata[3*i +: 3] == `IOSP_CFG_ANALOG)
							cfg_r[i+10] <= 3'h0; // R4
						else
							cfg_r[i+10] <= pwdata[3*i +: 3]; // R1
				default: ;
			endcase
		end
	end

	// APB read and handshake
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup && (paddr > `IOSP_ADDR_RESULT || paddr[1:0] != 2'h0);
			prdata  <= 32'h00000000;
			if (rd)
			begin
				unique case (paddr)
					`IOSP_ADDR_RATE:     prdata <= {16'h0000, sample_rate_r};
					`IOSP_ADDR_CHG_MASK: prdata <= {12'h000, change_detect_mask_r};
					`IOSP_ADDR_DEST_HI:  prdata <= {16'h0000, dest_addr_high};
					`IOSP_ADDR_DEST_LO:  prdata <= {16'h0000, dest_addr_low};
					`IOSP_ADDR_PULL_EN:  prdata <= {12'h000, pull_resistor_enable};
					`IOSP_ADDR_PULL_DIR: prdata <= {12'h000, pull_direction};
					`IOSP_ADDR_AREF:     prdata <= {30'h00000000, analog_reference_select};
					`IOSP_ADDR_CFG_LO:
						for (int i = 0; i < 10; i++)
							prdata[3*i +: 3] <= cfg_r[i];
					`IOSP_ADDR_CFG_HI:
						for (int i = 0; i < 10; i++)
							prdata[3*i +: 3] <= cfg_r[i+10];
					`IOSP_ADDR_STATUS:   prdata <= {12'h000, din_level_r};
					`IOSP_ADDR_IRQ_STAT: prdata <= {29'h00000000, irq_stat_r};
					`IOSP_ADDR_IRQ_MASK: prdata <= {29'h00000000, irq_mask_r};
					`IOSP_ADDR_PROTO:    prdata <= {30'h00000000, frame_protocol_select_r};
					`IOSP_ADDR_RESULT:   prdata <= result_r;
					default:             prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Pin drive
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			general_pin_out <= 20'h00000;
			general_pin_oe  <= 20'h00000;
		end
		else
		begin
			general_pin_out <= dout_hi; // R2
			general_pin_oe  <= dmask & ~(din_mask_f(dmask, dout_hi)); // R2
		end
	end

	function automatic logic [19:0] din_mask_f(input logic [19:0] m, input logic [19:0] h);
		logic [19:0] r;
		r = 20'h00000;
		for (int i = 0; i < `IOSP_NUM_LINES; i++)
			r[i] = m[i] && (cfg_r[i] == `IOSP_CFG_DIN);
		return r;
	endfunction

	// Input synchronisers, level accepted when stages two and three agree
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sync1_r     <= 20'h00000;
			sync2_r     <= 20'h00000;
			sync3_r     <= 20'h00000;
			din_level_r <= 20'h00000;
			din_prev_r  <= 20'h00000;
		end
		else
		begin
			sync1_r     <= general_pin_in;
			sync2_r     <= sync1_r;
			sync3_r     <= sync2_r;
			din_level_r <= (sync2_r & sync3_r) | (din_level_r & (sync2_r | sync3_r));
			din_prev_r  <= din_level_r;
		end
	end

	// Sample-rate timer, one unit per tick
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			tick_cnt_r <= 16'h0000;
			rate_cnt_r <= 16'h0000;
		end
		else if (sample_rate_r == 16'h0000 || wake_req)
		begin
			tick_cnt_r <= 16'(`IOSP_TICK_CYCLES - 1);
			rate_cnt_r <= sample_rate_r;
		end
		else if (tick_cnt_r == 16'h0000)
		begin
			tick_cnt_r <= 16'(`IOSP_TICK_CYCLES - 1);
			rate_cnt_r <= (rate_cnt_r <= 16'h0001) ? sample_rate_r : rate_cnt_r - 16'h0001; // R8
		end
		else
			tick_cnt_r <= tick_cnt_r - 16'h0001;
	end

	// Pending requests, one per source
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			pend_timer_r  <= 1'b0;
			pend_change_r <= 1'b0;
			pend_demand_r <= 1'b0;
		end
		else
		begin
			if (timer_hit || (wake_req && sample_rate_r != 16'h0000))
				pend_timer_r <= 1'b1; // R8 R11
			else if (start && !pend_demand_r)
				pend_timer_r <= 1'b0;
			if (change_hit)
				pend_change_r <= 1'b1; // R9 R11
			else if (start && !pend_demand_r && !pend_timer_r)
				pend_change_r <= 1'b0;
			if (is_req)
				pend_demand_r <= 1'b1; // R10 R11
			else if (start)
				pend_demand_r <= 1'b0;
		end
	end

	// Record packer
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			state_r      <= IOSP_IDLE;
			lo_half_r    <= 1'b0;
			ach_r        <= 2'h0;
			cap_dmask_r  <= 20'h00000;
			cap_dstate_r <= 20'h00000;
			cap_amask_r  <= 4'h0;
			cap_aval_r   <= 40'h0000000000;
			sample_valid <= 1'b0;
			sample_byte  <= 8'h00;
			sample_last  <= 1'b0;
			sample_src   <= IOSP_SRC_NONE;
		end
		else if (adv)
		begin
			sample_valid <= 1'b0;
			sample_last  <= 1'b0;
			unique case (state_r)
				IOSP_IDLE:
					if (start && ((|dmask) || (|amask))) // R6
					begin
						cap_dmask_r  <= dmask; // R10
						cap_dstate_r <= (din_level_r & din_mask_f(dmask, dout_hi)) | dout_hi;
						cap_amask_r  <= amask;
						cap_aval_r   <= analog_value;
						sample_src   <= pend_demand_r ? IOSP_SRC_DEMAND :
							(pend_timer_r ? IOSP_SRC_TIMER : IOSP_SRC_CHANGE); // R7
						state_r      <= IOSP_COUNT;
					end
				IOSP_COUNT:
				begin
					sample_valid <= 1'b1;
					sample_byte  <= `IOSP_SAMPLE_SETS; // R12
					lo_half_r    <= 1'b0;
					state_r      <= IOSP_DMASK;
				end
				IOSP_DMASK:
				begin
					sample_valid <= 1'b1;
					sample_byte  <= lo_half_r ? cap_dmask_r[7:0] : cap_dmask_r[15:8]; // R17 R18
					lo_half_r    <= !lo_half_r;
					if (lo_half_r)
						state_r <= IOSP_AMASK;
				end
				IOSP_AMASK:
				begin
					sample_valid <= 1'b1;
					sample_byte  <= {4'h0, cap_amask_r}; // R13
					lo_half_r    <= 1'b0;
					ach_r        <= 2'h0;
					sample_last  <= (cap_dmask_r[15:0] == 16'h0000) && (cap_amask_r == 4'h0);
					state_r      <= (cap_dmask_r[15:0] != 16'h0000) ? IOSP_DDATA :
						((cap_amask_r != 4'h0) ? IOSP_ADATA : IOSP_IDLE); // R14 R15
				end
				IOSP_DDATA:
				begin
					sample_valid <= 1'b1;
					sample_byte  <= lo_half_r ? cap_dstate_r[7:0] : cap_dstate_r[15:8]; // R14 R18
					lo_half_r    <= !lo_half_r;
					sample_last  <= lo_half_r && (cap_amask_r == 4'h0);
					if (lo_half_r)
						state_r <= (cap_amask_r != 4'h0) ? IOSP_ADATA : IOSP_IDLE;
				end
				IOSP_ADATA:
					if (!cap_amask_r[ach_r])
						ach_r <= ach_r + 2'h1; // R15
					else
					begin
						sample_valid <= 1'b1;
						sample_byte  <= lo_half_r ? cap_aval_r[10*ach_r +: 8] :
							{6'h00, cap_aval_r[10*ach_r+8 +: 2]}; // R5 R18
						lo_half_r    <= !lo_half_r;
						if (lo_half_r)
						begin
							ach_r       <= ach_r + 2'h1;
							sample_last <= (amask_rest == 4'h0);
							if (amask_rest == 4'h0)
								state_r <= IOSP_IDLE;
						end
					end
				default: state_r <= IOSP_IDLE;
			endcase
		end
	end

	// Demand result, sticky events, interrupt
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			result_r   <= 32'h00000000;
			irq_stat_r <= 3'h0;
			irq        <= 1'b0;
		end
		else
		begin
			if (state_r == IOSP_IDLE && start && !((|dmask) || (|amask)) && pend_demand_r)
				result_r <= 32'h00000001;
			else if (state_r == IOSP_IDLE && start && pend_demand_r)
				result_r <= 32'h00000000;
			irq_stat_r[`IOSP_IRQ_DONE_BIT] <= (sample_valid && sample_ready && sample_last) ||
				(irq_stat_r[`IOSP_IRQ_DONE_BIT] && !(rd && paddr == `IOSP_ADDR_IRQ_STAT));
			irq_stat_r[`IOSP_IRQ_ERR_BIT] <= (state_r == IOSP_IDLE && start && !((|dmask) || (|amask))) ||
				(irq_stat_r[`IOSP_IRQ_ERR_BIT] && !(rd && paddr == `IOSP_ADDR_IRQ_STAT)); // R6
			irq_stat_r[`IOSP_IRQ_DROP_BIT] <= ((timer_hit && pend_timer_r) || (change_hit && pend_change_r)) ||
				(irq_stat_r[`IOSP_IRQ_DROP_BIT] && !(rd && paddr == `IOSP_ADDR_IRQ_STAT));
			irq <= |(irq_stat_r & irq_mask_r);
		end
	end

endmodule

// ### hdl/iosp_pkg.sv
// Types for the sample packer
package iosp_pkg;
	typedef enum logic [2:0]
	{
		IOSP_IDLE   = 3'b000,
		IOSP_COUNT  = 3'b001,
		IOSP_DMASK  = 3'b010,
		IOSP_AMASK  = 3'b011,
		IOSP_DDATA  = 3'b100,
		IOSP_ADATA  = 3'b101
	} iosp_state_t;
	typedef enum logic [1:0]
	{
		IOSP_SRC_NONE   = 2'b00,
		IOSP_SRC_TIMER  = 2'b01,
		IOSP_SRC_CHANGE = 2'b10,
		IOSP_SRC_DEMAND = 2'b11
	} iosp_src_t;
endpackage

// ### verif/iosp_packer_sva.sv
// Port assertions for the sample packer
module iosp_packer_sva
(
	// Clock and reset
	input wire logic                ref_clk,
	input wire logic                rstn,
	// APB
	input wire logic                psel,
	input wire logic                penable,
	input wire logic [11:0]         paddr,
	input wire logic                pready,
	input wire logic [31:0]         prdata,
	input wire logic                pslverr,
	// Pins
	input wire logic [19:0]         general_pin_out,
	input wire logic [19:0]         general_pin_oe,
	// Sample stream
	input wire logic                sample_valid,
	input wire logic [7:0]          sample_byte,
	input wire logic                sample_last,
	input wire iosp_pkg::iosp_src_t sample_src,
	input wire logic                sample_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	import iosp_pkg::*;
	logic in_rec_r;
	// Inside a record once a non-final byte is taken
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			in_rec_r <= 1'b0;
		else if (sample_valid && sample_ready)
			in_rec_r <= !sample_last;
	end
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	a_apb_answer:
		assert property (psel && !penable |=> pready) else $error("no answer after setup");
	a_apb_refuse:
		assert property (psel && !penable && paddr > 12'h038 |=> pready && pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_pin_drive:
		assert property ((general_pin_out & ~general_pin_oe) == 20'h0) else $error("high output not enabled");
	a_unused_lines:
		assert property (general_pin_oe[11:10] == 2'b00) else $error("unused line driven");
	a_first_byte:
		assert property (sample_valid && !in_rec_r |-> sample_byte == 8'h01) else $error("bad set count");
	a_byte_hold:
		assert property (sample_valid && !sample_ready |=> sample_valid && $stable(sample_byte) && $stable(sample_last))
		else $error("byte dropped while stalled");
	a_src_stable:
		assert property (sample_valid && !(sample_ready && sample_last) |=> $stable(sample_src))
		else $error("source changed in record");
	a_record_gap:
		assert property (sample_valid && sample_ready && sample_last |=> !sample_valid) else $error("no idle gap");
	a_src_known:
		assert property (sample_valid |-> sample_src != IOSP_SRC_NONE) else $error("record without source");
endmodule

// ### verif/iosp_packer_test.sv
// Self-checking bench for the sample packer
`include "iosp_defs.svh"
module iosp_packer_test;
	timeunit 1ns;
	timeprecision 1ps;
	import iosp_pkg::*;
	logic        ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, slow = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rdata;
	logic [19:0] general_pin_in = 20'h00001, general_pin_out, general_pin_oe, pull_resistor_enable, pull_direction;
	logic [1:0]  analog_reference_select;
	logic [39:0] analog_value = {10'h0AB, 10'h155, 10'h3FF, 10'h124};
	logic        sample_valid, sample_last, sample_ready;
	logic [7:0]  sample_byte;
	logic [15:0] dest_addr_high, dest_addr_low;
	iosp_src_t   sample_src;
	logic [7:0]  exq[$];
	int          error_cnt = 0, n_checks = 0, nrec = 0;
	iosp_packer u_iosp_packer (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
		.pslverr, .general_pin_in, .general_pin_out, .general_pin_oe, .pull_resistor_enable, .pull_direction,
		.analog_reference_select, .analog_value, .sample_valid, .sample_byte, .sample_last, .sample_src,
		.dest_addr_high, .dest_addr_low, .sample_ready, .irq);
	iosp_sink u_iosp_sink (.ref_clk, .rstn, .sample_valid, .sample_byte, .sample_last, .sample_src,
		.sample_ready, .slow);
	always #5 ref_clk = ~ref_clk;
	task complete_run;
		$display("checks=%0d errors=%0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One APB transfer, held until pready, then one edge for the write to settle
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do
			@(posedge ref_clk);
		while (pready !== 1'b1);
		rdata = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Expected record for lines 0,2,3,12 digital and line 1 analog
	task exp_rec(input logic [15:0] ds);
		logic [63:0] v;
		v = {8'h01, 16'h100D, 8'h02, ds, 16'h03FF};
		for (int i = 7; i >= 0; i--)
			exq.push_back(v[8*i+:8]);
	endtask
	task wait_rec(input int n);
		int k;
		k = 0;
		while (u_iosp_sink.n_rec < nrec + n && k < 600)
		begin
			@(posedge ref_clk);
			k++;
		end
		nrec += n;
		chk(u_iosp_sink.n_rec, nrec);
		chk(u_iosp_sink.got.size(), exq.size());
		foreach (exq[i])
			chk(u_iosp_sink.got[i], exq[i]);
		u_iosp_sink.got.delete();
		exq.delete();
	endtask
	task t_reset;
		chk(pull_resistor_enable, 20'hFFFFF);
		chk(pull_direction, 20'hFFFFF);
		apb(0, `IOSP_ADDR_PULL_EN, 0);
		chk(rdata, 32'h000FFFFF);
		apb(1, `IOSP_ADDR_PULL_DIR, 32'h00002);
		chk(pull_direction, 20'h00002);
		apb(1, `IOSP_ADDR_AREF, 32'h3);
		chk(analog_reference_select, 2'h3);
		apb(0, 12'h03C, 0);
		chk(rdata, 32'h0);
	endtask
	task t_config;
		apb(1, `IOSP_ADDR_CFG_LO, 32'h2953);
		apb(0, `IOSP_ADDR_CFG_LO, 0);
		chk(rdata[14:12], 3'h0);
		chk(rdata[11:0], 12'h953);
		apb(1, `IOSP_ADDR_CFG_HI, 32'h145);
		@(posedge ref_clk);
		chk(general_pin_oe, 20'h0100C);
		chk(general_pin_out, 20'h01004);
	endtask
	task t_demand;
		slow <= 1'b1;
		apb(1, `IOSP_ADDR_IRQ_MASK, 32'h1);
		exp_rec(16'h1005);
		apb(1, `IOSP_ADDR_CTRL, 32'h1);
		wait_rec(1);
		chk(u_iosp_sink.last_src, IOSP_SRC_DEMAND);
		repeat (3) @(posedge ref_clk);
		chk(irq, 1'b1);
		apb(0, `IOSP_ADDR_IRQ_STAT, 0);
		chk(rdata[0], 1'b1);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b0);
		slow <= 1'b0;
	endtask
	task t_change;
		apb(1, `IOSP_ADDR_DEST_HI, 32'h1234);
		apb(1, `IOSP_ADDR_DEST_LO, 32'h5678);
		apb(1, `IOSP_ADDR_CHG_MASK, 32'h1);
		general_pin_in <= 20'h0;
		exp_rec(16'h1004);
		wait_rec(1);
		chk(u_iosp_sink.last_src, IOSP_SRC_CHANGE);
		chk(dest_addr_high, 16'h1234);
		chk(dest_addr_low, 16'h5678);
		general_pin_in <= 20'h1;
		repeat (8) @(posedge ref_clk);
		apb(1, `IOSP_ADDR_CTRL, 32'h1);
		exp_rec(16'h1005);
		exp_rec(16'h1005);
		wait_rec(2);
		apb(1, `IOSP_ADDR_CHG_MASK, 32'h0);
	endtask
	task t_timer;
		apb(1, `IOSP_ADDR_RATE, 32'h1);
		exp_rec(16'h1005);
		wait_rec(1);
		chk(u_iosp_sink.last_src, IOSP_SRC_TIMER);
		apb(1, `IOSP_ADDR_RATE, 32'h0);
		apb(1, `IOSP_ADDR_CTRL, 32'h2);
		repeat (20) @(posedge ref_clk);
		chk(u_iosp_sink.n_rec, nrec);
		u_iosp_sink.got.delete();
		nrec = u_iosp_sink.n_rec;
		apb(1, `IOSP_ADDR_RATE, 32'h100);
		apb(1, `IOSP_ADDR_CTRL, 32'h2);
		exp_rec(16'h1005);
		wait_rec(1);
		chk(u_iosp_sink.last_src, IOSP_SRC_TIMER);
		apb(1, `IOSP_ADDR_CTRL, 32'h6);
		repeat (50) @(posedge ref_clk);
		chk(u_iosp_sink.n_rec, nrec);
		apb(1, `IOSP_ADDR_RATE, 32'h0);
	endtask
	task t_empty;
		apb(1, `IOSP_ADDR_IRQ_MASK, 32'h2);
		apb(1, `IOSP_ADDR_CFG_LO, 32'h0);
		apb(1, `IOSP_ADDR_CFG_HI, 32'h0);
		apb(1, `IOSP_ADDR_CTRL, 32'h1);
		repeat (30) @(posedge ref_clk);
		chk(u_iosp_sink.n_rec, nrec);
		apb(0, `IOSP_ADDR_RESULT, 0);
		chk(rdata[0], 1'b1);
		chk(irq, 1'b1);
	endtask
	initial
	begin
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		t_reset();
		t_config();
		t_demand();
		t_change();
		t_timer();
		t_empty();
		complete_run();
	end
	initial
	begin
		#200000;
		error_cnt++;
		complete_run();
	end
endmodule
bind iosp_packer iosp_packer_sva u_iosp_packer_sva (.ref_clk, .rstn, .psel, .penable, .paddr, .pready, .prdata,
	.pslverr, .general_pin_out, .general_pin_oe, .sample_valid, .sample_byte, .sample_last, .sample_src,
	.sample_ready);

// ### verif/iosp_sink.sv
// Receiving-side model that accepts and logs sample bytes
module iosp_sink
(
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rstn,
	// Sample stream
	input  wire logic                sample_valid,
	input  wire logic [7:0]          sample_byte,
	input  wire logic                sample_last,
	input  wire iosp_pkg::iosp_src_t sample_src,
	output logic                     sample_ready,
	// Stall control
	input  wire logic                slow
);
	timeunit 1ns;
	timeprecision 1ps;
	import iosp_pkg::*;
	logic [7:0] got[$];
	int         n_rec;
	iosp_src_t  last_src;
	// Accept bytes, stalling every other cycle when slow
	always @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			sample_ready <= 1'b0;
			n_rec        <= 0;
		end
		else
		begin
			sample_ready <= slow ? ~sample_ready : 1'b1;
			if (sample_valid && sample_ready)
			begin
				got.push_back(sample_byte);
				last_src <= sample_src;
				if (sample_last)
					n_rec <= n_rec + 1;
			end
		end
	end
endmodule
